// File: hdl/pio_top.sv
// What this block does
// RULE1: a high heat or setback request turns heaters on and enables setback.
// RULE2: a low request turns heaters off and disables setback.
// RULE3: remote request restricts panel control; discrete inputs then steer the unit.
// RULE4: no automatic crossover under remote; controller decides from reported states.
// RULE5: contacts 1,2 carry run state low/high; 3,4 error state low/high.
// RULE6: run 00 off, 01 heat on, 10 at temp, 11 pump on at temp.
// RULE7: error 00 none, 01 drum low, 10 drum empty, 11 alarm.
// RULE8: every contact is open while the unit is unpowered or reset.
// RULE9: the alarm contact closes whenever an alarm is present.
// RULE10: setback accepted only at least the offset below setpoint.
// RULE11: hose zones only on odd positions 1 to 11.
// RULE12: zero specific gravity selects pump cycle count display.
// RULE13: autostart switches the pump on once all zones reach setpoint.
// RULE14: schedule enables and disables heat and setback at programmed times.
// RULE15: inputs synchronised; output state codes come from registered state.
`timescale 1ns/1ps
`default_nettype none
module pio_top #(
  parameter int unsigned TICK_CYCLES = pio_pkg::TICK_CYCLES
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic heat_req, // request connector: heat on
  input wire logic setback_req, // request connector: setback
  input wire logic pump_req, // request connector: pump on
  input wire logic remote_req, // request connector: remote takeover
  input wire logic zones_at_temp, // zone control board: all zones at setpoint
  input wire logic drum_low, // active unit drum low
  input wire logic drum_empty, // active unit drum empty
  input wire logic alarm_in, // alarm present in system
  output logic [3:0] state_contacts, // state output connector, 1 = closed
  output logic heaters_on, // heater enable
  output logic setback_on, // setback enable
  output logic pump_on, // pump enable
  output logic panel_restricted, // local display panel restricted
  output logic auto_crossover, // automatic crossover enabled
  output logic cycle_count_display, // home display shows cycle count
  output logic irq // interrupt, level high
);

  // ****************************************
  // input synchronising
  // ****************************************
  logic [pio_pkg::IN_W-1:0] pins_sync;

  pio_sync #(.W(pio_pkg::IN_W)) u_sync ( // see RULE15
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d({alarm_in, drum_empty, drum_low, zones_at_temp,
        remote_req, pump_req, setback_req, heat_req}),
    .q(pins_sync)
  );

  wire s_heat = pins_sync[pio_pkg::IN_HEAT];
  wire s_setback = pins_sync[pio_pkg::IN_SETBACK];
  wire s_pump = pins_sync[pio_pkg::IN_PUMP];
  wire s_remote = pins_sync[pio_pkg::IN_REMOTE];
  wire s_at_temp = pins_sync[pio_pkg::IN_AT_TEMP];
  wire s_low = pins_sync[pio_pkg::IN_DRUM_LOW];
  wire s_empty = pins_sync[pio_pkg::IN_DRUM_EMPTY];
  wire s_alarm = pins_sync[pio_pkg::IN_ALARM];

  // ****************************************
  // registers
  // ****************************************
  logic [pio_pkg::CTRL_W-1:0] ctrl;
  logic [pio_pkg::IRQ_W-1:0] int_status;
  logic [pio_pkg::IRQ_W-1:0] int_mask;
  logic [15:0] setpoint;
  logic [15:0] setback_temp;
  logic [pio_pkg::ZONES-1:0] zone_type;
  logic [15:0] spgrav;
  logic [16:0] sched_on;
  logic [16:0] sched_off;
  logic [16:0] tod;
  logic [31:0] tick_cnt;
  logic remote_q;
  logic alarm_q;
  logic [1:0] run_q;

  // ****************************************
  // apb decode
  // ****************************************
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_ctrl = paddr == pio_pkg::OFF_CTRL;
  wire hit_status = paddr == pio_pkg::OFF_STATUS;
  wire hit_ist = paddr == pio_pkg::OFF_INT_STATUS;
  wire hit_imask = paddr == pio_pkg::OFF_INT_MASK;
  wire hit_temp = paddr == pio_pkg::OFF_TEMP;
  wire hit_zone = paddr == pio_pkg::OFF_ZONE_TYPE;
  wire hit_spg = paddr == pio_pkg::OFF_SPGRAV;
  wire hit_sched = paddr == pio_pkg::OFF_SCHED;
  wire hit_tod = paddr == pio_pkg::OFF_TOD;
  wire mapped = hit_ctrl | hit_status | hit_ist | hit_imask | hit_temp |
                hit_zone | hit_spg | hit_sched | hit_tod;

  // setback must sit at least the offset below setpoint, unit chosen in ctrl
  wire [15:0] sb_offset = ctrl[pio_pkg::CTRL_CELSIUS] ?
                          pio_pkg::SETBACK_OFFSET_C : pio_pkg::SETBACK_OFFSET_F;
  wire [16:0] sb_limit = {1'b0, pwdata[31:16]} + {1'b0, sb_offset};
  wire temp_ok = sb_limit <= {1'b0, pwdata[15:0]}; // see RULE10
  // a hose flag on an even-numbered zone is a bad configuration
  wire zone_ok = (pwdata[pio_pkg::ZONES-1:0] & ~pio_pkg::HOSE_ALLOWED) == '0; // see RULE11
  wire sched_ok = pwdata[16:0] < pio_pkg::SECONDS_PER_DAY &&
                  {1'b0, pwdata[31:16]} < pio_pkg::SECONDS_PER_DAY;
  wire tod_ok = pwdata[16:0] < pio_pkg::SECONDS_PER_DAY;
  wire cfg_bad = (hit_temp && !temp_ok) || (hit_zone && !zone_ok) ||
                 (hit_sched && !sched_ok) || (hit_tod && !tod_ok);
  wire cfg_reject = wr && cfg_bad;
  wire err_now = !mapped || (pwrite && (hit_status || cfg_bad));

  // ****************************************
  // operating logic
  // ****************************************
  wire tick = tick_cnt == TICK_CYCLES - 1;
  wire [16:0] tod_inc = (tod == pio_pkg::SECONDS_PER_DAY - 17'h00001) ? 17'h00000 :
                        tod + 17'h00001;
  wire sched_win = (sched_on <= sched_off) ? (tod >= sched_on && tod < sched_off) :
                   (tod >= sched_on || tod < sched_off);
  wire sched_act = ctrl[pio_pkg::CTRL_SCHED_EN] && sched_win; // see RULE14
  // pin requests override panel bits while the controller holds remote
  wire next_heat = s_remote ? s_heat : (ctrl[pio_pkg::CTRL_HEAT] || sched_act); // see RULE1
  wire next_setback = s_remote ? s_setback :
                      (ctrl[pio_pkg::CTRL_SETBACK] || sched_act); // see RULE2
  wire autostart = ctrl[pio_pkg::CTRL_AUTOSTART] && s_at_temp;
  wire pump_ask = s_remote ? s_pump : (ctrl[pio_pkg::CTRL_PUMP] || autostart); // see RULE13
  // air motor stays locked until heat is at temperature
  wire next_pump = pump_ask && next_heat && s_at_temp;
  wire [1:0] next_run = next_pump ? pio_pkg::RUN_PUMP_ON :
                        (next_heat && s_at_temp) ? pio_pkg::RUN_AT_TEMP :
                        next_heat ? pio_pkg::RUN_HEAT_ON : pio_pkg::RUN_OFF; // see RULE6
  wire [1:0] next_err = s_alarm ? pio_pkg::ERR_ALARM :
                        s_empty ? pio_pkg::ERR_DRUM_EMPTY :
                        s_low ? pio_pkg::ERR_DRUM_LOW : pio_pkg::ERR_NONE; // see RULE7

  wire [pio_pkg::IRQ_W-1:0] irq_events;
  assign irq_events[pio_pkg::IRQ_ALARM] = s_alarm && !alarm_q;
  assign irq_events[pio_pkg::IRQ_CFG_REJECT] = cfg_reject;
  assign irq_events[pio_pkg::IRQ_REMOTE_CHG] = s_remote != remote_q;
  assign irq_events[pio_pkg::IRQ_RUN_CHG] = next_run != run_q;
  // set wins over the read clear in the same cycle
  wire ist_clr = rd && hit_ist;
  // only bits already reported in prdata are cleared, so a late event is not lost
  wire [pio_pkg::IRQ_W-1:0] next_ist = (ist_clr ? (int_status & ~prdata[pio_pkg::IRQ_W-1:0]) :
                                        int_status) | irq_events;

  wire [31:0] status_word = {22'h000000, cycle_count_display, auto_crossover,
                             panel_restricted, pump_on, setback_on, heaters_on,
                             state_contacts};
  wire [31:0] rd_mux = hit_ctrl ? {25'h0000000, ctrl} :
                       hit_status ? status_word :
                       hit_ist ? {28'h0000000, int_status} :
                       hit_imask ? {28'h0000000, int_mask} :
                       hit_temp ? {setback_temp, setpoint} :
                       hit_zone ? {20'h00000, zone_type} :
                       hit_spg ? {16'h0000, spgrav} :
                       hit_sched ? {sched_off[14:0], 1'b0, sched_on[15:0]} :
                       hit_tod ? {15'h0000, tod} : 32'h00000000;

  // ****************************************
  // apb slave, one wait-free access phase
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup && err_now;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= pio_pkg::CTRL_RESET;
      int_mask <= pio_pkg::IRQ_RESET;
      setpoint <= pio_pkg::SETPOINT_RESET;
      setback_temp <= pio_pkg::SETBACK_RESET;
      zone_type <= pio_pkg::ZONE_TYPE_RESET;
      spgrav <= pio_pkg::SPGRAV_RESET;
      sched_on <= pio_pkg::SCHED_RESET;
      sched_off <= pio_pkg::SCHED_RESET;
    end else if (ce && wr) begin
      if (hit_ctrl) begin
        ctrl <= pwdata[pio_pkg::CTRL_W-1:0];
      end
      if (hit_imask) begin
        int_mask <= pwdata[pio_pkg::IRQ_W-1:0];
      end
      if (hit_temp && temp_ok) begin // see RULE10
        setpoint <= pwdata[15:0];
        setback_temp <= pwdata[31:16];
      end
      if (hit_zone && zone_ok) begin // see RULE11
        zone_type <= pwdata[pio_pkg::ZONES-1:0];
      end
      if (hit_spg) begin
        spgrav <= pwdata[15:0];
      end
      if (hit_sched && sched_ok) begin
        sched_on <= pwdata[16:0];
        sched_off <= {1'b0, pwdata[31:16]};
      end
    end
  end

  // time of day in seconds, software may set it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h00000000;
      tod <= pio_pkg::SCHED_RESET;
    end else if (ce) begin
      tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
      if (wr && hit_tod && tod_ok) begin
        tod <= pwdata[16:0];
      end else if (tick) begin
        tod <= tod_inc;
      end
    end
  end

  // ****************************************
  // outputs and interrupt
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_contacts <= 4'h0; // see RULE8
      heaters_on <= 1'b0;
      setback_on <= 1'b0;
      pump_on <= 1'b0;
      panel_restricted <= 1'b0;
      auto_crossover <= 1'b0;
      cycle_count_display <= 1'b0;
      int_status <= pio_pkg::IRQ_RESET;
      irq <= 1'b0;
      remote_q <= 1'b0;
      alarm_q <= 1'b0;
      run_q <= pio_pkg::RUN_OFF;
    end else if (ce) begin
      state_contacts <= {next_err, next_run}; // see RULE5
      heaters_on <= next_heat; // see RULE1
      setback_on <= next_setback; // see RULE2
      pump_on <= next_pump;
      panel_restricted <= s_remote; // see RULE3
      auto_crossover <= !s_remote && ctrl[pio_pkg::CTRL_XOVER]; // see RULE4
      cycle_count_display <= spgrav == 16'h0000; // see RULE12
      int_status <= next_ist;
      irq <= |(next_ist & int_mask);
      remote_q <= s_remote;
      alarm_q <= s_alarm;
      run_q <= next_run;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_remote_heat;
    ce && s_remote && s_heat;
  endsequence
  sequence s_ce2;
    ce [*2];
  endsequence

  property p_heat_follows;
    @(posedge pclk) disable iff (!presetn)
    s_remote_heat ##1 ce |-> heaters_on && $past(s_heat);
  endproperty
  a_heat_follows: assert property (p_heat_follows) else $error("heater not on"); // see RULE1

  property p_heat_off;
    @(posedge pclk) disable iff (!presetn)
    ce && s_remote && !s_heat |=> !heaters_on && !pump_on;
  endproperty
  a_heat_off: assert property (p_heat_off) else $error("heater not off"); // see RULE2

  property p_setback;
    @(posedge pclk) disable iff (!presetn)
    ce && s_remote |=> setback_on == $past(s_setback);
  endproperty
  a_setback: assert property (p_setback) else $error("setback wrong"); // see RULE2

  property p_restrict;
    @(posedge pclk) disable iff (!presetn)
    ce |=> panel_restricted == $past(s_remote);
  endproperty
  a_restrict: assert property (p_restrict) else $error("panel not restricted"); // see RULE3

  property p_no_xover;
    @(posedge pclk) disable iff (!presetn)
    panel_restricted |-> !auto_crossover;
  endproperty
  a_no_xover: assert property (p_no_xover) else $error("crossover under remote"); // see RULE4

  property p_alarm_code;
    @(posedge pclk) disable iff (!presetn)
    s_ce2 ##0 s_alarm |=> state_contacts[3:2] == pio_pkg::ERR_ALARM;
  endproperty
  a_alarm_code: assert property (p_alarm_code) else $error("alarm contact open"); // see RULE9

  property p_pump_code;
    @(posedge pclk) disable iff (!presetn)
    pump_on |-> state_contacts[1:0] == pio_pkg::RUN_PUMP_ON && heaters_on;
  endproperty
  a_pump_code: assert property (p_pump_code) else $error("run code wrong"); // see RULE6

  property p_err_low;
    @(posedge pclk) disable iff (!presetn)
    ce && s_low && !s_empty && !s_alarm |=> state_contacts[3:2] == pio_pkg::ERR_DRUM_LOW;
  endproperty
  a_err_low: assert property (p_err_low) else $error("drum low code wrong"); // see RULE7

  property p_temp_reject;
    @(posedge pclk) disable iff (!presetn)
    ce && wr && hit_temp && !temp_ok |=> $stable(setpoint) && $stable(setback_temp);
  endproperty
  a_temp_reject: assert property (p_temp_reject) else $error("bad setback stored"); // see RULE10

  property p_zone_odd;
    @(posedge pclk) disable iff (!presetn)
    (zone_type & ~pio_pkg::HOSE_ALLOWED) == '0;
  endproperty
  a_zone_odd: assert property (p_zone_odd) else $error("hose on even zone"); // see RULE11

  property p_display;
    @(posedge pclk) disable iff (!presetn)
    ce && presetn ##1 ce |-> cycle_count_display == ($past(spgrav) == 16'h0000);
  endproperty
  a_display: assert property (p_display) else $error("display mode wrong"); // see RULE12

  property p_autostart;
    @(posedge pclk) disable iff (!presetn)
    ce && !s_remote && ctrl[pio_pkg::CTRL_AUTOSTART] && next_heat && s_at_temp |=> pump_on;
  endproperty
  a_autostart: assert property (p_autostart) else $error("autostart failed"); // see RULE13

  property p_sched;
    @(posedge pclk) disable iff (!presetn)
    ce && !s_remote && sched_act |=> heaters_on && setback_on;
  endproperty
  a_sched: assert property (p_sched) else $error("schedule ignored"); // see RULE14

endmodule
`default_nettype wire

// File: hdl/pio_pkg.sv
package pio_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_TIME_S = 1;
  localparam int unsigned TICK_CYCLES = TICK_TIME_S * CLK_HZ;
  localparam logic [16:0] SECONDS_PER_DAY = 17'h15180;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_INT_STATUS = 8'h08;
  localparam logic [7:0] OFF_INT_MASK = 8'h0C;
  localparam logic [7:0] OFF_TEMP = 8'h10;
  localparam logic [7:0] OFF_ZONE_TYPE = 8'h14;
  localparam logic [7:0] OFF_SPGRAV = 8'h18;
  localparam logic [7:0] OFF_SCHED = 8'h1C;
  localparam logic [7:0] OFF_TOD = 8'h20;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_HEAT = 0;
  localparam int CTRL_SETBACK = 1;
  localparam int CTRL_PUMP = 2;
  localparam int CTRL_AUTOSTART = 3;
  localparam int CTRL_SCHED_EN = 4;
  localparam int CTRL_CELSIUS = 5;
  localparam int CTRL_XOVER = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // ****************************************
  // interrupt bits
  // ****************************************
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_CFG_REJECT = 1;
  localparam int IRQ_REMOTE_CHG = 2;
  localparam int IRQ_RUN_CHG = 3;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  // ****************************************
  // configuration limits and resets
  // ****************************************
  localparam logic [15:0] SETBACK_OFFSET_F = 16'h0014;
  localparam logic [15:0] SETBACK_OFFSET_C = 16'h000A;
  localparam logic [15:0] SETPOINT_RESET = 16'h0000;
  localparam logic [15:0] SETBACK_RESET = 16'h0000;
  localparam int ZONES = 12;
  localparam logic [ZONES-1:0] HOSE_ALLOWED = 12'h555;
  localparam logic [ZONES-1:0] ZONE_TYPE_RESET = 12'h000;
  localparam logic [15:0] SPGRAV_RESET = 16'h0000;
  localparam logic [16:0] SCHED_RESET = 17'h00000;

  // ****************************************
  // input pin positions after synchronising
  // ****************************************
  localparam int IN_HEAT = 0;
  localparam int IN_SETBACK = 1;
  localparam int IN_PUMP = 2;
  localparam int IN_REMOTE = 3;
  localparam int IN_AT_TEMP = 4;
  localparam int IN_DRUM_LOW = 5;
  localparam int IN_DRUM_EMPTY = 6;
  localparam int IN_ALARM = 7;
  localparam int IN_W = 8;

  // ****************************************
  // state codes on the output contacts
  // ****************************************
  localparam logic [1:0] RUN_OFF = 2'h0;
  localparam logic [1:0] RUN_HEAT_ON = 2'h1;
  localparam logic [1:0] RUN_AT_TEMP = 2'h2;
  localparam logic [1:0] RUN_PUMP_ON = 2'h3;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_DRUM_LOW = 2'h1;
  localparam logic [1:0] ERR_DRUM_EMPTY = 2'h2;
  localparam logic [1:0] ERR_ALARM = 2'h3;

endpackage

// File: hdl/pio_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pio_sync #(
  parameter int W = 8
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised inputs
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// File: verification/pio_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
module pio_plc_model (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic [7:0] cmd, // wanted pin levels, pio_pkg::IN_ order
  output logic [7:0] pins // request and plant status pins
);
  // ****************************************
  // controller outputs
  // ****************************************
  // levels move only after an edge; pins copy cmd, the bench decides every level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= 8'h00;
    end else begin
      pins <= cmd;
    end
  end
endmodule
`default_nettype wire

// File: verification/pio_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pio_top_bench;
  // ****************************************
  // signals, design and partner
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] cmd = 8'h00;
  logic [7:0] pins;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] junk;
  logic pready, pslverr, jerr, irq;
  logic heaters_on, setback_on, pump_on, panel_restricted, auto_crossover, cycle_count_display;
  logic [3:0] state_contacts;
  int fails = 0;
  int n_checks = 0;
  always #4 pclk = ~pclk;
  pio_plc_model plc (.pclk(pclk), .presetn(presetn), .cmd(cmd), .pins(pins));
  // short tick keeps the schedule run brief
  pio_top #(.TICK_CYCLES(10)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .heat_req(pins[pio_pkg::IN_HEAT]), .setback_req(pins[pio_pkg::IN_SETBACK]),
    .pump_req(pins[pio_pkg::IN_PUMP]), .remote_req(pins[pio_pkg::IN_REMOTE]),
    .zones_at_temp(pins[pio_pkg::IN_AT_TEMP]), .drum_low(pins[pio_pkg::IN_DRUM_LOW]),
    .drum_empty(pins[pio_pkg::IN_DRUM_EMPTY]), .alarm_in(pins[pio_pkg::IN_ALARM]),
    .state_contacts(state_contacts), .heaters_on(heaters_on), .setback_on(setback_on),
    .pump_on(pump_on), .panel_restricted(panel_restricted), .auto_crossover(auto_crossover),
    .cycle_count_display(cycle_count_display), .irq(irq));
  // ****************************************
  // tasks
  // ****************************************
  task stop_test;
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // entered just after a rising edge; leaves one idle cycle so psel is never set twice
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && i < 20) begin
      i++;
      @(posedge pclk);
    end
    if (i == 20) begin
      fails++;
      $display("[ERR] %0t apb timeout", $time);
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(a, 1'b1, d, junk, jerr);
    chk({31'h0, jerr}, {31'h0, ee}, "write response");
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
    apb(a, 1'b0, 32'h0, junk, jerr);
    chk(junk, x, "read data");
    chk({31'h0, jerr}, {31'h0, ee}, "read response");
  endtask
  // partner latency plus two sync stages and the output stage
  task pin(input logic [7:0] c);
    cmd <= c;
    repeat (6) @(posedge pclk);
  endtask
  task outs(input logic [3:0] c, input logic [2:0] hsp);
    chk({28'h0, state_contacts}, {28'h0, c}, "contacts");
    chk({29'h0, heaters_on, setback_on, pump_on}, {29'h0, hsp}, "heat setback pump");
  endtask
  task wait_heat(input logic v);
    int i;
    i = 0;
    while (heaters_on !== v && i < 100) begin
      i++;
      @(posedge pclk);
    end
    chk({31'h0, heaters_on}, {31'h0, v}, "scheduled heat");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge pclk);
    outs(4'h0, 3'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(pio_pkg::OFF_CTRL, 32'h0, 1'b0);
    rd(pio_pkg::OFF_INT_MASK, 32'h0, 1'b0);
    rd(pio_pkg::OFF_TEMP, 32'h0, 1'b0);
    rd(pio_pkg::OFF_ZONE_TYPE, 32'h0, 1'b0);
    rd(pio_pkg::OFF_STATUS, 32'h00000200, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(pio_pkg::OFF_STATUS, 32'hFFFFFFFF, 1'b1);
    // local heat and crossover bits must be overridden by the remote pins
    wr(pio_pkg::OFF_CTRL, 32'h00000041, 1'b0);
    pin(8'h09);
    outs(4'h1, 3'h4);
    chk({30'h0, panel_restricted, auto_crossover}, 32'h2, "remote");
    pin(8'h19);
    outs(4'h2, 3'h4);
    pin(8'h1D);
    outs(4'h3, 3'h5);
    pin(8'h0A);
    outs(4'h0, 3'h2);
    pin(8'h08);
    outs(4'h0, 3'h0);
    pin(8'h00);
    outs(4'h1, 3'h4);
    chk({30'h0, panel_restricted, auto_crossover}, 32'h1, "local");
    // clock enable low must hold every flop, sync stages included
    ce <= 1'b0;
    pin(8'h19);
    outs(4'h1, 3'h4);
    ce <= 1'b1;
    pin(8'h00);
    outs(4'h1, 3'h4);
    pin(8'h20);
    chk({28'h0, state_contacts}, 32'h5, "drum low");
    pin(8'h40);
    chk({28'h0, state_contacts}, 32'h9, "drum empty");
    pin(8'hE0);
    chk({28'h0, state_contacts}, 32'hD, "alarm");
    wr(pio_pkg::OFF_CTRL, 32'h00000009, 1'b0);
    pin(8'h10);
    outs(4'h3, 3'h5);
    wr(pio_pkg::OFF_CTRL, 32'h00000000, 1'b0);
    pin(8'h00);
    apb(pio_pkg::OFF_INT_STATUS, 1'b0, 32'h0, junk, jerr);
    wr(pio_pkg::OFF_INT_MASK, 32'h0, 1'b0);
    pin(8'h80);
    chk({31'h0, irq}, 32'h0, "masked irq");
    rd(pio_pkg::OFF_INT_STATUS, 32'h1, 1'b0);
    pin(8'h00);
    wr(pio_pkg::OFF_INT_MASK, 32'h1, 1'b0);
    pin(8'h80);
    chk({31'h0, irq}, 32'h1, "irq");
    rd(pio_pkg::OFF_INT_STATUS, 32'h1, 1'b0);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    pin(8'h00);
    wr(pio_pkg::OFF_TEMP, 32'h00500064, 1'b0);
    wr(pio_pkg::OFF_TEMP, 32'h00510064, 1'b1);
    rd(pio_pkg::OFF_TEMP, 32'h00500064, 1'b0);
    wr(pio_pkg::OFF_CTRL, 32'h00000020, 1'b0);
    wr(pio_pkg::OFF_TEMP, 32'h005B0064, 1'b1);
    wr(pio_pkg::OFF_TEMP, 32'h005A0064, 1'b0);
    wr(pio_pkg::OFF_ZONE_TYPE, 32'h00000555, 1'b0);
    wr(pio_pkg::OFF_ZONE_TYPE, 32'h00000002, 1'b1);
    rd(pio_pkg::OFF_ZONE_TYPE, 32'h00000555, 1'b0);
    wr(pio_pkg::OFF_SPGRAV, 32'h00000005, 1'b0);
    @(posedge pclk);
    chk({31'h0, cycle_count_display}, 32'h0, "mass display");
    wr(pio_pkg::OFF_SPGRAV, 32'h00000000, 1'b0);
    @(posedge pclk);
    chk({31'h0, cycle_count_display}, 32'h1, "cycle display");
    wr(pio_pkg::OFF_SCHED, 32'h00680066, 1'b0);
    wr(pio_pkg::OFF_TOD, 32'h00000062, 1'b0);
    wr(pio_pkg::OFF_CTRL, 32'h00000010, 1'b0);
    chk({31'h0, heaters_on}, 32'h0, "before window");
    wait_heat(1'b1);
    wait_heat(1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
